//--- verilog/ipps_sequencer.sv
// Interleaved 2/3/4 phase pulse sequencer with digital current balance
// Behaviour
// - Cycle starts when phase 1 forced low
// - Four channels: quarter-cycle termination spacing
// - Phase 3 strapped high: two channels, half
// - Phase 4 strapped high, phase 3 low: three channels, third
// - Low output held at least quarter cycle
// - After off time, rise at ramp crossing
// - High output held until next termination
// - Sample current once per cycle after settling
// - Disabled channels' sense paths kept inactive
// - Average equals active sum over count
// - Filtered imbalance adjusts each comparison level
// - Held samples feed balance and the held sample output
`timescale 1ns/10ps
`include "ipps_params.svh"
module ipps_sequencer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic phase3_strap_in,
  input wire logic phase4_strap_in,
  input wire ipps_pkg::ipps_cnt_t comp_level_in,
  input wire ipps_pkg::ipps_cur_t current_sense_in [4],
  output ipps_pkg::ipps_pulse_t pulse_out,
  output logic [2:0] active_channels,
  output ipps_pkg::ipps_cur_t average_channel_current,
  output ipps_pkg::ipps_cur_t held_sample_out [4]
);
  import ipps_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  logic rst_s1_reg, rst_n_reg;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Termination offset of channel k for n active channels
  function automatic ipps_cnt_t term_pos(input int k, input logic [2:0] n);
    ipps_cnt_t len;
    len = `IPPS_CYCLE_LEN;
    if (n == 3'd2) begin
      term_pos = 12'(k * (len / 2));
    end else if (n == 3'd3) begin
      term_pos = 12'(k * (len / 3));
    end else begin
      term_pos = 12'(k * (len / 4));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Strap capture and cycle counter
  ipps_state_t state_reg, state_next;
  logic [2:0] nch_reg, nch_next; // Active channel count
  ipps_cnt_t cnt_reg, cnt_next; // Single phase counter
  always_comb begin
    state_next = state_reg;
    nch_next = nch_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      IPPS_ST_STRAP: begin
        // Outputs still low, so the straps read the board, not us
        if (phase3_strap_in) begin
          nch_next = 3'd2;
        end else if (phase4_strap_in) begin
          nch_next = 3'd3;
        end else begin
          nch_next = 3'd4;
        end
        cnt_next = 12'h000;
        state_next = IPPS_ST_RUN;
      end
      IPPS_ST_RUN: begin
        // Wraps every cycle; all phase instants come from here
        if (cnt_reg == `IPPS_CYCLE_LEN - 12'h001) begin
          cnt_next = 12'h000;
        end else begin
          cnt_next = cnt_reg + 12'h001;
        end
      end
      default: state_next = IPPS_ST_STRAP;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= IPPS_ST_STRAP;
      nch_reg <= 3'd4;
      cnt_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      nch_reg <= nch_next;
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Average of held samples over active channels
  ipps_cur_t samp_reg [4];
  ipps_cur_t samp_next [4];
  ipps_cur_t avg_reg, avg_next;
  logic [13:0] sum;
  always_comb begin
    sum = 14'h0000;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(nch_reg)) begin
        sum = sum + 14'(samp_reg[i]);
      end
    end
    // Divider is combinational; fine at this slow clock
    avg_next = 12'(sum / 14'(nch_reg));
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-channel pulse, sampling and balance loop
  logic [3:0] pulse_reg, pulse_next;
  ipps_cnt_t off_reg [4];
  ipps_cnt_t off_next [4];
  ipps_err_t filt_reg [4];
  ipps_err_t filt_next [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_ch
      logic act;
      ipps_err_t err;
      ipps_err_t lvl;
      ipps_cnt_t ramp;
      assign act = (g < int'(nch_reg)) && (state_reg == IPPS_ST_RUN);
      always_comb begin
        pulse_next[g] = pulse_reg[g];
        off_next[g] = off_reg[g];
        samp_next[g] = samp_reg[g];
        filt_next[g] = filt_reg[g];
        // Ramp restarts at this channel's termination
        ramp = cnt_reg - term_pos(g, nch_reg) + ((cnt_reg < term_pos(g, nch_reg)) ? `IPPS_CYCLE_LEN : 12'h000);
        err = 14'(samp_reg[g]) - 14'(avg_reg);
        // High channel current raises its level, delaying the rise and narrowing its pulse
        // Signed cast keeps the shift arithmetic; an unsigned mix would turn it logical
        lvl = $signed(14'(comp_level_in)) + (filt_reg[g] >>> `IPPS_FILT_SH);
        if (!act) begin
          pulse_next[g] = 1'b0;
          off_next[g] = 12'h000;
          samp_next[g] = 12'h000;
          filt_next[g] = 14'sh0000;
        end else if (cnt_reg == term_pos(g, nch_reg)) begin
          pulse_next[g] = 1'b0;
          off_next[g] = 12'h000;
          filt_next[g] = filt_reg[g] + ((err - filt_reg[g]) >>> `IPPS_FILT_SH);
        end else if (!pulse_reg[g]) begin
          if (off_reg[g] != `IPPS_CYCLE_LEN) begin
            off_next[g] = off_reg[g] + 12'h001;
          end
          if (off_reg[g] == `IPPS_SETTLE_CYC) begin
            samp_next[g] = current_sense_in[g];
          end
          // Off time must cover a quarter cycle before re-enabling
          if (off_reg[g] >= (`IPPS_CYCLE_LEN >> 2) - 12'h001 && $signed({2'b00, ramp}) >= lvl) begin
            pulse_next[g] = 1'b1;
          end
        end
      end
      always_ff @(posedge core_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          pulse_reg[g] <= 1'b0;
          off_reg[g] <= 12'h000;
          samp_reg[g] <= 12'h000;
          filt_reg[g] <= 14'sh0000;
        end else begin
          pulse_reg[g] <= pulse_next[g];
          off_reg[g] <= off_next[g];
          samp_reg[g] <= samp_next[g];
          filt_reg[g] <= filt_next[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      avg_reg <= 12'h000;
    end else begin
      avg_reg <= avg_next;
    end
  end

  // Outputs straight from flops
  assign pulse_out = pulse_reg;
  assign active_channels = nch_reg;
  assign average_channel_current = avg_reg;
  assign held_sample_out = samp_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  phase1_term_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (state_reg == IPPS_ST_RUN && cnt_reg == 12'h000) |=> !pulse_reg[0]) else $error("phase 1 not ended");
  off_time_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    $fell(pulse_reg[0]) |-> off_reg[0] == 12'h000) else $error("off count not reset");
  min_off_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    $rose(pulse_reg[1]) |-> off_reg[1] >= 12'd59) else $error("off time short");
  strap_low_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    state_reg == IPPS_ST_STRAP |-> pulse_reg == 4'h0) else $error("pulse during strap");
  idle_ch_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (nch_reg == 3'd2) |=> !pulse_reg[2] && samp_reg[3] == 12'h000) else $error("idle channel active");
  two_ph_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (state_reg == IPPS_ST_RUN && nch_reg == 3'd2 && cnt_reg == 12'd120) |=> !pulse_reg[1]) else $error("ph2 spacing");
  four_ph_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (state_reg == IPPS_ST_RUN && nch_reg == 3'd4 && cnt_reg == 12'd180) |=> !pulse_reg[3]) else $error("ph4 spacing");
  three_ph_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (state_reg == IPPS_ST_RUN && nch_reg == 3'd3 && cnt_reg == 12'd160) |=> !pulse_reg[2]) else $error("ph3 spacing");
  sample_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (nch_reg != 3'd0 && state_reg == IPPS_ST_RUN && !pulse_reg[0] && off_reg[0] == 12'd8 && cnt_reg != 12'h000)
    |=> samp_reg[0] == $past(current_sense_in[0])) else $error("sample missed");
  wrap_a: assert property (@(posedge core_clk) disable iff (!rst_n_reg)
    (cnt_reg == 12'd239) |=> cnt_reg == 12'h000) else $error("counter wrap");
endmodule

//--- verilog/ipps_params.svh
// Constants for the interleaved phase pulse sequencer
`ifndef IPPS_PARAMS_SVH
`define IPPS_PARAMS_SVH
`define IPPS_CYCLE_LEN 12'd240
`define IPPS_SETTLE_CYC 12'd8
`define IPPS_NCH 4
`define IPPS_CUR_W 12
`define IPPS_ERR_W 14
`define IPPS_FILT_SH 2
`endif

//--- verilog/ipps_pkg.sv
// Types shared by the interleaved phase pulse sequencer
package ipps_pkg;
  typedef logic [11:0] ipps_cnt_t;
  typedef logic [11:0] ipps_cur_t;
  typedef logic signed [13:0] ipps_err_t;
  typedef struct packed {
    logic phase4_pulse_out;
    logic phase3_pulse_out;
    logic phase2_pulse_out;
    logic phase1_pulse_out;
  } ipps_pulse_t;
  typedef enum logic [1:0] {
    IPPS_ST_STRAP = 2'b00,
    IPPS_ST_RUN = 2'b01
  } ipps_state_t;
endpackage

//--- bench/ipps_drv_model.sv
// Half-bridge driver model for the far side of the four phase outputs
`timescale 1ns/10ps
module ipps_drv_model (
  input wire logic core_clk,
  input wire ipps_pkg::ipps_pulse_t pulse_in,
  output logic [3:0] upper_on,
  output logic [3:0] sync_on
);
  import ipps_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Dead time is not modelled, so the upper switch follows the pulse level and the sync switch its inverse, one clock later
  always_ff @(posedge core_clk) begin
    upper_on <= 4'(pulse_in);
    sync_on <= ~4'(pulse_in);
  end
endmodule

//--- bench/ipps_sequencer_tb.sv
// Self-checking bench for the interleaved phase pulse sequencer
`timescale 1ns/10ps
module ipps_sequencer_tb;
  import ipps_pkg::*;
  typedef struct {logic p3; logic p4; int n; int avg;} ipps_row_t;
  logic core_clk, arst_n, s3, s4;
  ipps_cnt_t comp;
  ipps_cur_t cur [4];
  ipps_cur_t held [4];
  ipps_cur_t avg_out;
  ipps_pulse_t pulse, pp;
  logic [2:0] act;
  logic [3:0] up_on, sy_on, seen_hi;
  int failures = 0, n_tests = 0, cyc = 0, drv_bad = 0;
  int fall_t [4], rise_t [4], low_w [4], high_w [4], offs [4], period, min_low;
  // Strap rows; the last one also straps phase 4 on a two-channel board
  ipps_row_t rows [4] = '{'{0, 0, 4, 250}, '{1, 0, 2, 150}, '{0, 1, 3, 200}, '{1, 1, 2, 150}};
  ipps_sequencer DUT (.core_clk(core_clk), .arst_n(arst_n), .phase3_strap_in(s3), .phase4_strap_in(s4),
    .comp_level_in(comp), .current_sense_in(cur), .pulse_out(pulse), .active_channels(act),
    .average_channel_current(avg_out), .held_sample_out(held));
  ipps_drv_model drv (.core_clk(core_clk), .pulse_in(pulse), .upper_on(up_on), .sync_on(sy_on));
  ////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      failures++;
      summarize();
    end
  end
  // Edge monitor, sampled mid-cycle where outputs are settled
  always @(negedge core_clk) begin
    // Driver must show the level taken at the last rising edge; skipped in reset
    if (arst_n && (up_on !== 4'(pp) || sy_on !== ~4'(pp))) drv_bad++;
    for (int k = 0; k < 4; k++) begin
      if (pp[k] && !pulse[k]) begin
        high_w[k] = cyc - rise_t[k];
        if (k == 0) period = cyc - fall_t[0];
        fall_t[k] = cyc;
        offs[k] = cyc - fall_t[0];
      end
      if (!pp[k] && pulse[k]) begin
        low_w[k] = cyc - fall_t[k];
        rise_t[k] = cyc;
        seen_hi[k] = 1'b1;
        if (low_w[k] < min_low) min_low = low_w[k];
      end
    end
    pp = pulse;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic run(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Straps flip after capture to prove they are taken only once
  task automatic do_reset(input logic a, input logic b);
    s3 = a;
    s4 = b;
    arst_n = 0;
    run(5);
    check(32'(pulse), 0);
    arst_n = 1;
    seen_hi = 0;
    min_low = 999;
    foreach (fall_t[k]) fall_t[k] = cyc;
    run(2);
    check(32'(pulse), 0);
    run(6);
    s3 = ~a;
    s4 = ~b;
  endtask
  task automatic summarize();
    $display("Counts: %0d checks, %0d failures", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 0;
    s3 = 0;
    s4 = 0;
    pp = '0;
    comp = 12'h050;
    cur = '{12'h064, 12'h0c8, 12'h12c, 12'h190};
    foreach (rows[r]) begin
      do_reset(rows[r].p3, rows[r].p4);
      run(1200);
      check(32'(act), rows[r].n);
      check(period, 240);
      for (int k = 1; k < rows[r].n; k++) check(offs[k], k * 240 / rows[r].n);
      for (int k = 0; k < 4; k++) check(32'(held[k]), k < rows[r].n ? 32'(cur[k]) : 0);
      check(32'(seen_hi), (1 << rows[r].n) - 1);
      check(32'(drv_bad), 0);
      check(32'(avg_out), rows[r].avg);
      check(min_low >= 60, 1);
      $display("Test strap row %0d done", r);
    end
    // Equal currents: rise follows the ramp crossing, then the forced off floor
    cur = '{4{12'h064}};
    comp = 12'h078;
    do_reset(0, 0);
    run(1200);
    check(low_w[1] >= 120 && low_w[1] <= 122, 1);
    check(high_w[1], 240 - low_w[1]);
    comp = 12'h000;
    run(720);
    check(low_w[2] >= 60 && low_w[2] <= 62, 1);
    $display("Test ramp crossing done");
    // A heavier channel must end up with the narrower pulse
    cur = '{12'h190, 12'h064, 12'h064, 12'h064};
    comp = 12'h078;
    run(2400);
    check(high_w[0] < high_w[1], 1);
    $display("Test current balance done");
    summarize();
  end
endmodule
